// [design/owc_dev.sv]
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - host fills bank pointer slots in order, four max
// - highest programmed slot picks the power-on bank
// - seven user banks, numbered one to seven
// - power-on copies six config words to RAM when a slot is programmed
// - fourteen RAM registers, six config first
// - byte is start, eight bits lsb first, stop
// - line idles high, falling edge starts byte
// - both sides only pull low, pull-up idles high
// - every transaction opens with 55h baud byte
// - bit rates from 4.8k to 114k accepted
// - command msb: 0 write, 1 read
// - command bit six: 1 otp, 0 ram
// - otp: bits 5:3 bank, 2:0 register
// - ram: bits 3:0 register index
// - two data bytes follow every command
// - read waits one bit after command stop
// - low byte first, then high byte
// - software_control_word bit 7 selects eight-bit wait
// - about 28 ms silence abandons the transaction
// - every byte after 55h restarts the inactivity timer
// - host keeps its rate within one percent
// - otp banks hold eight 16-bit words
// - config_word_c bit 15 silences the port
module owc_dev #(
    parameter int TIMEOUT_CYCLES = owc_pkg::TIMEOUT_CYC,
    parameter int PER_W = owc_pkg::PER_W
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic OTP_ERASE,
    owc_if.dev LINK,
    output logic [PER_W-1:0] BIT_PERIOD,
    output logic LINK_ACTIVE,
    output logic PORT_DISABLED,
    output logic [owc_pkg::CFG_REGS*owc_pkg::WORD_W-1:0] CFG_WORDS
);
    import owc_pkg::*;
    typedef enum logic [5:0] {
        ST_LOAD = 6'h01,
        ST_IDLE = 6'h02,
        ST_INIT = 6'h04,
        ST_BYTE = 6'h08,
        ST_TURN = 6'h10,
        ST_SEND = 6'h20
    } owc_dstate_e;
    localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam int MEAS_W = PER_W + INIT_SHIFT;
    localparam int TURN_W = PER_W + TURN_LONG_SH + 1;

    owc_word_t ram_q [RAM_REGS];
    owc_word_t otp_q [OTP_BANKS*OTP_REGS];
    owc_dstate_e st_q;
    logic [PER_W-1:0] per_q;
    logic [MEAS_W-1:0] meas_q;
    logic [2:0] falls_q;
    logic [1:0] nbyte_q;
    logic [7:0] cmd_q;
    logic [7:0] lo_q;
    logic [TURN_W-1:0] turn_q;
    logic [TMO_W-1:0] tmo_q;
    logic go_q;
    logic [7:0] go_byte_q;
    logic prev_q;
    logic [BANK_W-1:0] pon_bank;
    logic rx_done;
    logic tx_done;
    logic pull;
    logic [7:0] rx_byte;

    wire logic line = LINK.serial_config_pin;
    wire logic fall = prev_q && !line;
    wire logic cmd_rd = cmd_q[CMD_DIR_BIT];
    wire logic cmd_otp = cmd_q[CMD_OTP_BIT];
    wire logic [BANK_W+REG_W-1:0] otp_addr = cmd_q[OTP_ADDR_MSB:0];
    wire logic [RAM_IDX_MSB:0] ram_idx = cmd_q[RAM_IDX_MSB:0];
    wire logic ram_hit = (ram_idx < RAM_REGS);
    wire owc_word_t rd_word = cmd_otp ? otp_q[otp_addr] :
        (ram_hit ? ram_q[ram_idx] : '0);
    wire logic disabled = ram_q[IDX_CONFIG_WORD_C][SERIAL_PORT_DISABLE_BIT];
    wire logic long_turn = ram_q[IDX_SOFTWARE_CONTROL_WORD][TURNAROUND_DELAY_SELECT_BIT];
    wire logic [TURN_W-1:0] per_w = TURN_W'(per_q);
    // counted from mid stop bit: half a bit, then one or eight whole bits
    wire logic [TURN_W-1:0] turn_load = (per_w >> 1) +
        (long_turn ? (per_w << TURN_LONG_SH) : per_w);
    wire logic tmo_run = !(st_q == ST_IDLE || st_q == ST_LOAD);
    wire logic tmo_hit = tmo_run && (tmo_q == TMO_W'(TIMEOUT_CYCLES - 1));
    wire logic wr_now = (st_q == ST_BYTE) && rx_done && (nbyte_q == NB_HI) && !cmd_rd;
    wire owc_word_t wr_word = {rx_byte, lo_q};

    // last programmed slot wins; a zero pointer means an unused slot
    always_comb begin
        pon_bank = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (otp_q[SLOT0_IDX + i][BANK_W-1:0] != '0) begin
                pon_bank = otp_q[SLOT0_IDX + i][BANK_W-1:0];
            end
        end
    end

    owc_serdes #(.PER_W(PER_W)) u_serdes (
        .clk(CLK_SYS),
        .rst(RST),
        .per(per_q),
        .line_in(line),
        .rx_en(st_q == ST_BYTE),
        .tx_go(go_q),
        .tx_byte(go_byte_q),
        .pull_low(pull),
        .rx_done(rx_done),
        .tx_done(tx_done),
        .rx_byte(rx_byte)
    );

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_q <= ST_LOAD;
            per_q <= '0;
            meas_q <= '0;
            falls_q <= '0;
            nbyte_q <= NB_CMD;
            cmd_q <= '0;
            lo_q <= '0;
            turn_q <= '0;
            go_q <= 1'b0;
            go_byte_q <= '0;
            prev_q <= 1'b1;
        end else begin
            prev_q <= line;
            go_q <= 1'b0;
            meas_q <= meas_q + 1'b1;
            turn_q <= turn_q - 1'b1;
            if (tmo_hit) begin
                st_q <= ST_IDLE;
            end else begin
                unique case (st_q)
                    ST_LOAD: begin
                        st_q <= ST_IDLE;
                    end
                    ST_IDLE: begin
                        if (fall && !disabled) begin
                            st_q <= ST_INIT;
                            meas_q <= MEAS_W'(1);
                            falls_q <= '0;
                        end
                    end
                    ST_INIT: begin
                        if (meas_q > MEAS_MAX) begin
                            st_q <= ST_IDLE; // slower than the slowest rate
                        end else if (fall) begin
                            falls_q <= falls_q + 1'b1;
                            if (falls_q == INIT_LAST) begin
                                per_q <= meas_q[MEAS_W-1:INIT_SHIFT];
                                st_q <= ST_BYTE;
                                nbyte_q <= NB_CMD;
                            end
                        end
                    end
                    ST_BYTE: begin
                        if (rx_done) begin
                            unique case (nbyte_q)
                                NB_CMD: begin
                                    cmd_q <= rx_byte;
                                    if (rx_byte[CMD_DIR_BIT]) begin
                                        st_q <= ST_TURN;
                                        turn_q <= turn_load;
                                    end else begin
                                        nbyte_q <= NB_LO;
                                    end
                                end
                                NB_LO: begin
                                    lo_q <= rx_byte;
                                    nbyte_q <= NB_HI;
                                end
                                default: begin
                                    st_q <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                    ST_TURN: begin
                        if (turn_q == '0) begin
                            st_q <= ST_SEND;
                            go_q <= 1'b1;
                            go_byte_q <= rd_word[7:0];
                            nbyte_q <= NB_LO;
                        end
                    end
                    ST_SEND: begin
                        if (tx_done) begin
                            if (nbyte_q == NB_LO) begin
                                go_q <= 1'b1;
                                go_byte_q <= rd_word[15:8];
                                nbyte_q <= NB_HI;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tmo_q <= '0;
        end else if (!tmo_run || rx_done || tx_done) begin
            tmo_q <= '0;
        end else begin
            tmo_q <= tmo_q + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < RAM_REGS; i++) begin
                ram_q[i] <= RAM_POR;
            end
        end else if (st_q == ST_LOAD) begin
            if (pon_bank != '0) begin
                for (int i = 0; i < CFG_REGS; i++) begin
                    ram_q[i] <= otp_q[{pon_bank, REG_W'(i)}];
                end
            end
        end else if (wr_now && !cmd_otp && ram_hit) begin
            ram_q[ram_idx] <= wr_word;
        end
    end

    // fuse storage survives RST; programming can only set bits
    always_ff @(posedge CLK_SYS) begin
        if (OTP_ERASE) begin
            for (int i = 0; i < OTP_BANKS*OTP_REGS; i++) begin
                otp_q[i] <= '0;
            end
        end else if (wr_now && cmd_otp) begin
            otp_q[otp_addr] <= otp_q[otp_addr] | wr_word;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CFG_REGS; g++) begin : g_cfg
            assign CFG_WORDS[g*WORD_W +: WORD_W] = ram_q[g];
        end
    endgenerate

    assign LINK.dev_out = 1'b0;
    assign LINK.dev_oe = pull;
    assign BIT_PERIOD = per_q;
    assign LINK_ACTIVE = tmo_run;
    assign PORT_DISABLED = disabled;
endmodule
`default_nettype wire

// [design/owc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module owc_host #(
    parameter int TIMEOUT_CYCLES = owc_pkg::TIMEOUT_CYC,
    parameter int PER_W = owc_pkg::PER_W
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [owc_pkg::HADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    owc_if.host LINK
);
    import owc_pkg::*;
    typedef enum logic [2:0] {H_IDLE = 3'h1, H_SEND = 3'h2, H_RECV = 3'h4} owc_hstate_e;
    localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);

    owc_hstate_e st_q;
    logic [7:0] cmd_q;
    owc_word_t wdat_q;
    owc_word_t rdat_q;
    logic [PER_W-1:0] per_q;
    logic [1:0] nb_q;
    logic err_q;
    logic go_q;
    logic [7:0] go_byte_q;
    logic [TMO_W-1:0] tmo_q;
    logic rx_done;
    logic tx_done;
    logic pull;
    logic [7:0] rx_byte;

    wire logic idle = (st_q == H_IDLE);
    wire logic tmo_hit = (st_q == H_RECV) && (tmo_q == TMO_W'(TIMEOUT_CYCLES - 1));
    wire logic [31:0] rd_mux =
        (ADDR == HREG_CMD) ? {24'h000000, cmd_q} :
        (ADDR == HREG_WDATA) ? {16'h0000, wdat_q} :
        (ADDR == HREG_PERIOD) ? 32'(per_q) :
        (ADDR == HREG_STATUS) ? {30'h00000000, err_q, !idle} :
        (ADDR == HREG_RDATA) ? {16'h0000, rdat_q} : 32'h00000000;

    owc_serdes #(.PER_W(PER_W)) u_serdes (
        .clk(CLK_SYS),
        .rst(RST),
        .per(per_q),
        .line_in(LINK.serial_config_pin),
        .rx_en(st_q == H_RECV),
        .tx_go(go_q),
        .tx_byte(go_byte_q),
        .pull_low(pull),
        .rx_done(rx_done),
        .tx_done(tx_done),
        .rx_byte(rx_byte)
    );

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_q <= H_IDLE;
            cmd_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            per_q <= PER_W'(HOST_PER_POR);
            nb_q <= NB_CMD;
            err_q <= 1'b0;
            go_q <= 1'b0;
            go_byte_q <= '0;
        end else begin
            go_q <= 1'b0;
            unique case (st_q)
                H_IDLE: begin
                    if (WR && ADDR == HREG_WDATA) begin
                        wdat_q <= WDATA[15:0];
                    end
                    if (WR && ADDR == HREG_PERIOD) begin
                        per_q <= WDATA[PER_W-1:0];
                    end
                    if (WR && ADDR == HREG_CMD) begin
                        cmd_q <= WDATA[7:0];
                        st_q <= H_SEND;
                        go_q <= 1'b1;
                        go_byte_q <= INIT_BYTE;
                        nb_q <= NB_CMD;
                        err_q <= 1'b0;
                    end
                end
                H_SEND: begin
                    if (tx_done) begin
                        nb_q <= nb_q + 1'b1;
                        go_q <= 1'b1;
                        unique case (nb_q)
                            NB_CMD: begin
                                go_byte_q <= cmd_q;
                            end
                            NB_LO: begin
                                go_byte_q <= wdat_q[7:0];
                                if (cmd_q[CMD_DIR_BIT]) begin
                                    go_q <= 1'b0;
                                    st_q <= H_RECV;
                                    nb_q <= NB_LO;
                                end
                            end
                            NB_HI: begin
                                go_byte_q <= wdat_q[15:8];
                            end
                            NB_END: begin
                                go_q <= 1'b0;
                                st_q <= H_IDLE;
                            end
                        endcase
                    end
                end
                H_RECV: begin
                    if (tmo_hit) begin
                        err_q <= 1'b1;
                        st_q <= H_IDLE;
                    end else if (rx_done) begin
                        if (nb_q == NB_LO) begin
                            rdat_q[7:0] <= rx_byte;
                            nb_q <= NB_HI;
                        end else begin
                            rdat_q[15:8] <= rx_byte;
                            st_q <= H_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tmo_q <= '0;
        end else if (st_q != H_RECV || rx_done) begin
            tmo_q <= '0;
        end else begin
            tmo_q <= tmo_q + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RDATA <= '0;
        end else begin
            RDATA <= RD ? rd_mux : 32'h00000000;
        end
    end

    // open drain even when sending: the pull-up makes every high
    assign LINK.host_out = 1'b0;
    assign LINK.host_oe = pull;
endmodule
`default_nettype wire

// [design/owc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface owc_if;
    logic dev_out;
    logic dev_oe;
    logic host_out;
    logic host_oe;
    logic serial_config_pin;
    // pull-up wins unless an enabled driver pulls low
    assign serial_config_pin = !((dev_oe && !dev_out) || (host_oe && !host_out));
    modport dev(input serial_config_pin, output dev_out, output dev_oe);
    modport host(input serial_config_pin, output host_out, output host_oe);
endinterface
`default_nettype wire

// [design/owc_pkg.sv]
`default_nettype none
package owc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_MIN = 4800;
    localparam int BAUD_MAX = 114_000;
    localparam int BIT_MAX_CYC = (CLK_HZ + BAUD_MIN - 1) / BAUD_MIN;
    localparam int BIT_MIN_CYC = CLK_HZ / BAUD_MAX;
    localparam int PER_W = 12;
    localparam int TIMEOUT_MS = 28;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int BAUD_POR = 9600;
    localparam int HOST_PER_POR = CLK_HZ / BAUD_POR;
    localparam int WORD_W = 16;
    localparam logic [7:0] INIT_BYTE = 8'h55;
    // 55h shows four more falling edges after the start edge, the last one
    // eight bit periods after it
    localparam logic [2:0] INIT_LAST = 3'h3;
    localparam int INIT_SHIFT = 3;
    localparam int MEAS_MAX = BIT_MAX_CYC * 8;
    localparam logic [3:0] BIT_START = 4'h0;
    localparam logic [3:0] BIT_LAST_DATA = 4'h8;
    localparam logic [3:0] BIT_STOP = 4'h9;
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_OTP_BIT = 6;
    localparam int OTP_ADDR_MSB = 5;
    localparam int RAM_IDX_MSB = 3;
    localparam int TURN_LONG_SH = 3;
    localparam int RAM_REGS = 14;
    localparam int CFG_REGS = 6;
    localparam int OTP_BANKS = 8;
    localparam int OTP_REGS = 8;
    localparam int BANK_W = 3;
    localparam int REG_W = 3;
    localparam int SLOTS = 4;
    localparam int SLOT0_IDX = 4;
    localparam int IDX_CONFIG_WORD_C = 4;
    localparam int SERIAL_PORT_DISABLE_BIT = 15;
    localparam int IDX_SOFTWARE_CONTROL_WORD = 7;
    localparam int TURNAROUND_DELAY_SELECT_BIT = 7;
    localparam logic [15:0] RAM_POR = 16'h0000;
    localparam logic [1:0] NB_CMD = 2'h0;
    localparam logic [1:0] NB_LO = 2'h1;
    localparam logic [1:0] NB_HI = 2'h2;
    localparam logic [1:0] NB_END = 2'h3;
    localparam int HADDR_W = 5;
    localparam logic [4:0] HREG_CMD = 5'h00;
    localparam logic [4:0] HREG_WDATA = 5'h04;
    localparam logic [4:0] HREG_PERIOD = 5'h08;
    localparam logic [4:0] HREG_STATUS = 5'h0c;
    localparam logic [4:0] HREG_RDATA = 5'h10;
    typedef logic [WORD_W-1:0] owc_word_t;
endpackage
`default_nettype wire

// [design/owc_serdes.sv]
`timescale 1ns/1ps
`default_nettype none
module owc_serdes #(
    parameter int PER_W = owc_pkg::PER_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [PER_W-1:0] per,
    input wire logic line_in,
    input wire logic rx_en,
    input wire logic tx_go,
    input wire logic [7:0] tx_byte,
    output logic pull_low,
    output logic rx_done,
    output logic tx_done,
    output logic [7:0] rx_byte
);
    import owc_pkg::*;
    typedef enum logic [2:0] {SD_IDLE = 3'h1, SD_RX = 3'h2, SD_TX = 3'h4} owc_sd_e;
    owc_sd_e mode_q;
    logic [PER_W-1:0] cnt_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic prev_q;
    wire logic fall = prev_q && !line_in;
    wire logic tick = (cnt_q == '0);
    wire logic last = (bit_q == BIT_STOP);
    wire logic [PER_W-1:0] reload = per - 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= SD_IDLE;
            cnt_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            prev_q <= 1'b1;
            pull_low <= 1'b0;
            rx_done <= 1'b0;
            tx_done <= 1'b0;
            rx_byte <= '0;
        end else begin
            prev_q <= line_in;
            rx_done <= 1'b0;
            tx_done <= 1'b0;
            cnt_q <= cnt_q - 1'b1;
            unique case (mode_q)
                SD_IDLE: begin
                    if (tx_go) begin
                        mode_q <= SD_TX;
                        sh_q <= tx_byte;
                        bit_q <= BIT_START;
                        cnt_q <= reload;
                        pull_low <= 1'b1;
                    end else if (rx_en && fall) begin
                        mode_q <= SD_RX;
                        bit_q <= BIT_START;
                        cnt_q <= per >> 1;
                    end
                end
                SD_RX: begin
                    if (tick) begin
                        cnt_q <= reload;
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == BIT_START && line_in) begin
                            mode_q <= SD_IDLE;
                        end else if (last) begin
                            // a missing stop bit drops the byte
                            mode_q <= SD_IDLE;
                            rx_done <= line_in;
                            rx_byte <= sh_q;
                        end else if (bit_q != BIT_START) begin
                            sh_q <= {line_in, sh_q[7:1]};
                        end
                    end
                end
                SD_TX: begin
                    if (tick) begin
                        cnt_q <= reload;
                        bit_q <= bit_q + 1'b1;
                        if (last) begin
                            mode_q <= SD_IDLE;
                            tx_done <= 1'b1;
                        end else begin
                            pull_low <= (bit_q == BIT_LAST_DATA) ? 1'b0 : !sh_q[0];
                            sh_q <= sh_q >> 1;
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [tb/one_wire_config_link_test.sv]
`timescale 1ns/1ps
`default_nettype none
module one_wire_config_link_test;
    import owc_pkg::*;
    localparam int TMO = 3000;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic OTP_ERASE = 1'b1;
    logic [HADDR_W-1:0] ADDR = '0;
    logic [31:0] WDATA = '0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    logic [PER_W-1:0] BIT_PERIOD;
    logic LINK_ACTIVE;
    logic PORT_DISABLED;
    logic [CFG_REGS*WORD_W-1:0] CFG_WORDS;
    logic rdv = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] w[6];
    logic [15:0] lf = 16'h000e;
    logic [15:0] e1;
    logic [31:0] st;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t_short;
    int t_long;
    owc_if lnk();
    owc_dev #(.TIMEOUT_CYCLES(TMO)) i_owc_dev (.CLK_SYS(CLK_SYS), .RST(RST),
        .OTP_ERASE(OTP_ERASE), .LINK(lnk.dev), .BIT_PERIOD(BIT_PERIOD),
        .LINK_ACTIVE(LINK_ACTIVE), .PORT_DISABLED(PORT_DISABLED), .CFG_WORDS(CFG_WORDS));
    owc_host #(.TIMEOUT_CYCLES(TMO)) i_owc_host (.CLK_SYS(CLK_SYS), .RST(RST),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINK(lnk.host));
    owc_chk #(.TIMEOUT_CYCLES(TMO)) i_owc_chk (.CLK_SYS(CLK_SYS), .RST(RST),
        .dev_out(lnk.dev_out), .dev_oe(lnk.dev_oe), .host_out(lnk.host_out),
        .host_oe(lnk.host_oe), .serial_config_pin(lnk.serial_config_pin),
        .LINK_ACTIVE(LINK_ACTIVE), .PORT_DISABLED(PORT_DISABLED));
    always #50 CLK_SYS = ~CLK_SYS;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge CLK_SYS);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 st = RDATA;
    endtask
    // polling is bounded so a stuck busy flag ends in a failed check of st[0] before the cycle ceiling
    task automatic xact(input logic [7:0] cmd, input logic [15:0] v, input int per);
        wr(HREG_PERIOD, 32'(per));
        wr(HREG_WDATA, {16'h0000, v});
        wr(HREG_CMD, {24'h000000, cmd});
        st = 32'h1;
        for (int i = 0; i < 9000 && st[0]; i++) rd(HREG_STATUS);
        check(16'(st[0]), 16'h0000);
    endtask
    task automatic rdx(input logic [7:0] cmd, input logic [15:0] e);
        xact(cmd, 16'h0000, 96);
        exp_q.push_back(e);
        rd(HREG_RDATA);
        // busy drops at mid stop of the reply, so let that stop bit run out
        repeat (96) @(posedge CLK_SYS);
    endtask
    task automatic por;
        RST <= 1'b1;
        @(posedge CLK_SYS);
        RST <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
    endtask
    always @(posedge CLK_SYS) begin
        if (rdv) check(RDATA[15:0], exp_q.pop_front());
        rdv <= RD && ADDR == HREG_RDATA;
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (6) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        OTP_ERASE <= 1'b0;
        por();
        check(CFG_WORDS[15:0], 16'h0000);
        for (int k = 0; k < 6; k++) begin
            lf = lfsr(lf);
            w[k] = lf;
            xact(8'(k), lf, 88 + 8 * (k % 2));
            check(CFG_WORDS[16*k +: 16], lf);
            check(16'(BIT_PERIOD), 16'(88 + 8 * (k % 2)));
            if (k % 2) rdx(8'h80 | 8'(k), lf);
        end
        xact(8'h0e, 16'hffff, 88);
        t_short = cyc;
        rdx(8'h8e, 16'h0000);
        t_short = cyc - t_short;
        xact(8'h07, 16'h0080, 88);
        t_long = cyc;
        rdx(8'h82, w[2]);
        check(16'(cyc - t_long - t_short), 16'(((1 << TURN_LONG_SH) - 1) * 96));
        e1 = lfsr(lf);
        xact(8'h58, e1, 88);
        xact(8'h68, lf, 88);
        xact(8'h44, 16'h0003, 88);
        por();
        check(CFG_WORDS[15:0], e1);
        check(CFG_WORDS[31:16], 16'h0000);
        xact(8'h45, 16'h0005, 88);
        por();
        check(CFG_WORDS[15:0], lf);
        rdx(8'hd8, e1);
        xact(8'h04, 16'h8000, 88);
        check(16'(PORT_DISABLED), 16'h0001);
        xact(8'h80, 16'h0000, 88);
        check(16'(st[1]), 16'h0001);
        wrap_up();
    end
endmodule
`default_nettype wire

// [tb/owc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module owc_chk #(
    parameter int TIMEOUT_CYCLES = 3000
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic host_out,
    input wire logic host_oe,
    input wire logic serial_config_pin,
    input wire logic LINK_ACTIVE,
    input wire logic PORT_DISABLED
);
    import owc_pkg::*;
    int quiet_q;
    logic pin_q;
    // reset loads a large gap so the first start bit is not taken for a short stop
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            quiet_q <= 'h100000;
            pin_q <= 1'b1;
        end else begin
            pin_q <= serial_config_pin;
            quiet_q <= (pin_q != serial_config_pin) ? 0 : quiet_q + 1;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_dev_low; dev_oe |-> !dev_out; endproperty
    a_dev_low: assert property (p_dev_low) else $error("device drives high");
    property p_host_low; host_oe |-> !host_out; endproperty
    a_host_low: assert property (p_host_low) else $error("host drives high");
    property p_idle_high; !dev_oe && !host_oe |-> serial_config_pin; endproperty
    a_idle_high: assert property (p_idle_high) else $error("line low when free");
    property p_dev_quiet; !LINK_ACTIVE |-> !dev_oe; endproperty
    a_dev_quiet: assert property (p_dev_quiet) else $error("pull outside frame");
    property p_no_clash; dev_oe |-> !host_oe; endproperty
    a_no_clash: assert property (p_no_clash) else $error("both pull");
    property p_turn; $rose(dev_oe) |-> quiet_q >= BIT_MIN_CYC; endproperty
    a_turn: assert property (p_turn) else $error("reply starts early");
    property p_host_gap; $rose(host_oe) |-> quiet_q >= BIT_MIN_CYC; endproperty
    a_host_gap: assert property (p_host_gap) else $error("stop bit short");
    property p_start; $rose(LINK_ACTIVE) |-> quiet_q < 8; endproperty
    a_start: assert property (p_start) else $error("start not on fall");
    property p_tmo; LINK_ACTIVE |-> quiet_q < TIMEOUT_CYCLES + BIT_MAX_CYC; endproperty
    a_tmo: assert property (p_tmo) else $error("no timeout");
    property p_off; PORT_DISABLED && !LINK_ACTIVE |=> !LINK_ACTIVE; endproperty
    a_off: assert property (p_off) else $error("disabled port woke");
endmodule
`default_nettype wire
